// >>> wtc_pkg.sv
// shared constants, types and helpers for the word-time counters
package wtc_pkg;

    localparam int          WTC_SHIFT_PULSES = 14;
    localparam logic [3:0]  WTC_WRAP_CNT     = 4'(WTC_SHIFT_PULSES);
    localparam logic [3:0]  WTC_CNT_RST      = 4'h0;
    localparam int          WTC_SEC_W        = 12;
    localparam int          WTC_RTC_SECTIONS = 3;

    typedef enum logic [1:0] {
        WTC_CTL_IDLE  = 2'h0,
        WTC_CTL_READ  = 2'h1,
        WTC_CTL_SHIFT = 2'h2,
        WTC_CTL_EMIT  = 2'h3
    } wtc_ctl_t;

    typedef struct packed {
        logic     sel;
        wtc_ctl_t code;
    } wtc_instr_t;

    typedef struct packed {
        logic [2:0] shift;
        logic [2:0] word;
    } wtc_timing_t;

    function automatic logic wtc_maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

endpackage

// >>> wtc_counters.sv
// timing generator, real-time counter and sample-rate counter
// Functional notes
// - 14 shift pulses, then one word pulse
// - triplicated pulses, majority voted at receivers
// - three lockstep counters, voted wrap reset
// - command picks one of two sources
// - real-time count in cascaded 12-bit sections
// - low section every word, others on carry
// - read-in steps through sections cyclically
// - emit restarts section selection at the low section
// - divided-clock buffer loads low section
// - 12-bit reload from external holding register
// - overflow reloads value, counting continues
// - overflow sets interrupt except in a read-in word, emit clears it
// - read-in reloads sample counter at the word boundary
// - sample counter may step on rtc overflow
// - one count-step circuit serves both counters
// - control code 00 idle,01 read,10 shift,11 emit
module wtc_counters
    import wtc_pkg::*;
#(
    parameter int SEC_W    = WTC_SEC_W,
    parameter int SECTIONS = WTC_RTC_SECTIONS
) (
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic              src_clk_a,
    input  wire logic              src_clk_b,
    input  wire logic              src_select,
    input  wire wtc_instr_t        rtc_instr,
    input  wire wtc_instr_t        srt_instr,
    input  wire logic [SEC_W-1:0]  srt_reload,
    input  wire logic              srt_step_by_rtc,
    output wtc_timing_t            timing_out,
    output logic [SEC_W-1:0]       rtc_dout,
    output logic                   rtc_overflow,
    output logic [SEC_W-1:0]       div_clk_out,
    output logic [SEC_W-1:0]       srt_count,
    output logic                   srt_irq
);

    localparam int PW = (SECTIONS > 1) ? $clog2(SECTIONS) : 1;

    // single count-step circuit, returns {carry, next}
    function automatic logic [SEC_W:0] cnt_step(input logic [SEC_W-1:0] v, input logic en);
        return {1'b0, v} + {{SEC_W{1'b0}}, en};
    endfunction

    // ---------------- source synchronisers and timing generator ----------------
    logic [2:0]       src_a_q;
    logic [2:0]       src_b_q;
    logic [1:0]       sel_q;
    logic [3:0]       tg_cnt_q [3];
    logic [3:0]       tg_cnt_d [3];
    logic [2:0]       tg_shift_q;
    logic [2:0]       tg_shift_d;
    logic [2:0]       tg_word_q;
    logic [2:0]       tg_word_d;
    logic             src_edge;
    logic             wrap_vote;
    logic             word_tick;

    always_comb begin
        // stage 0 of each synchroniser feeds only stage 1
        src_edge = sel_q[1] ? (src_b_q[1] & ~src_b_q[2]) : (src_a_q[1] & ~src_a_q[2]);
        wrap_vote = wtc_maj3({tg_cnt_q[2] == WTC_WRAP_CNT, tg_cnt_q[1] == WTC_WRAP_CNT,
                              tg_cnt_q[0] == WTC_WRAP_CNT});
        for (int i = 0; i < 3; i++) begin
            tg_cnt_d[i]   = tg_cnt_q[i];
            tg_shift_d[i] = 1'b0;
            tg_word_d[i]  = 1'b0;
            if (src_edge) begin
                // voted wrap keeps a stray counter from drifting the others
                tg_cnt_d[i]   = wrap_vote ? WTC_CNT_RST : 4'(tg_cnt_q[i] + 4'h1);
                tg_shift_d[i] = (tg_cnt_q[i] != WTC_WRAP_CNT);
                tg_word_d[i]  = (tg_cnt_q[i] == WTC_WRAP_CNT);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            src_a_q    <= 3'h0;
            src_b_q    <= 3'h0;
            sel_q      <= 2'h0;
            tg_shift_q <= 3'h0;
            tg_word_q  <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                tg_cnt_q[i] <= WTC_CNT_RST;
            end
        end else begin
            src_a_q    <= {src_a_q[1:0], src_clk_a};
            src_b_q    <= {src_b_q[1:0], src_clk_b};
            sel_q      <= {sel_q[0], src_select};
            tg_shift_q <= tg_shift_d;
            tg_word_q  <= tg_word_d;
            tg_cnt_q   <= tg_cnt_d;
        end
    end

    // internal receivers vote the three copies like any other module
    assign word_tick  = wtc_maj3(tg_word_q);
    assign timing_out = '{shift: tg_shift_q, word: tg_word_q};

    // ---------------- instruction decode and pending flags ----------------
    logic rtc_rd_pend_q, rtc_rd_pend_d, rtc_em_pend_q, rtc_em_pend_d;
    logic srt_rd_pend_q, srt_rd_pend_d, srt_em_pend_q, srt_em_pend_d;
    logic rtc_rd, rtc_em, srt_rd, srt_em;

    always_comb begin
        // idle and shift codes leave the counters alone
        rtc_rd = rtc_rd_pend_q | (rtc_instr.sel & (rtc_instr.code == WTC_CTL_READ));
        rtc_em = rtc_em_pend_q | (rtc_instr.sel & (rtc_instr.code == WTC_CTL_EMIT));
        srt_rd = srt_rd_pend_q | (srt_instr.sel & (srt_instr.code == WTC_CTL_READ));
        srt_em = srt_em_pend_q | (srt_instr.sel & (srt_instr.code == WTC_CTL_EMIT));
        // held until the word boundary that ends the instruction
        rtc_rd_pend_d = rtc_rd & ~word_tick;
        rtc_em_pend_d = rtc_em & ~word_tick;
        srt_rd_pend_d = srt_rd & ~word_tick;
        srt_em_pend_d = srt_em & ~word_tick;
    end

    // ---------------- real-time counter ----------------
    logic [SEC_W-1:0] sec_q [SECTIONS];
    logic [SEC_W-1:0] sec_d [SECTIONS];
    logic [SECTIONS-1:0] carry_q, carry_d;
    logic [PW-1:0]    ptr_q, ptr_d, ptr_sel;
    logic [SEC_W-1:0] rtc_dout_q, rtc_dout_d;
    logic [SEC_W-1:0] div_q, div_d;
    logic             rtc_ovf_q, rtc_ovf_d;

    always_comb begin
        logic [SEC_W:0] st;
        st         = '0;
        sec_d      = sec_q;
        carry_d    = carry_q;
        ptr_d      = ptr_q;
        rtc_dout_d = rtc_dout_q;
        div_d      = div_q;
        rtc_ovf_d  = rtc_ovf_q;
        ptr_sel    = rtc_em ? '0 : ptr_q;
        if (word_tick) begin
            for (int i = 0; i < SECTIONS; i++) begin
                // section i steps one word after section i-1 wrapped
                // index clamped so the unused branch never selects below bit 0
                st         = cnt_step(sec_q[i], (i == 0) ? 1'b1 : carry_q[(i > 0) ? i - 1 : 0]);
                sec_d[i]   = st[SEC_W-1:0];
                carry_d[i] = st[SEC_W];
            end
            rtc_ovf_d = carry_d[SECTIONS-1];
            div_d     = sec_q[0];
            ptr_d     = ptr_sel;
            if (rtc_rd) begin
                rtc_dout_d = sec_q[ptr_sel];
                ptr_d = (ptr_sel == PW'(SECTIONS - 1)) ? '0 : PW'(ptr_sel + 1'b1);
            end
        end
    end

    // ---------------- sample-rate counter ----------------
    logic [SEC_W-1:0] srt_q, srt_d;
    logic             irq_q, irq_d;
    logic             srt_set;

    always_comb begin
        logic [SEC_W:0] st;
        // slow rates: step only on a real-time counter wrap
        st      = cnt_step(srt_q, srt_step_by_rtc ? rtc_ovf_q : 1'b1);
        srt_d   = srt_q;
        srt_set = 1'b0;
        if (word_tick) begin
            srt_set = st[SEC_W] & ~srt_rd;
            if (srt_rd | st[SEC_W]) begin
                srt_d = srt_reload;
            end else begin
                srt_d = st[SEC_W-1:0];
            end
        end
        // a wrap in the clearing word still raises the flag
        irq_d = srt_set | (irq_q & ~(word_tick & srt_em));
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rtc_rd_pend_q <= 1'b0;
            rtc_em_pend_q <= 1'b0;
            srt_rd_pend_q <= 1'b0;
            srt_em_pend_q <= 1'b0;
            carry_q       <= '0;
            ptr_q         <= '0;
            rtc_dout_q    <= '0;
            div_q         <= '0;
            rtc_ovf_q     <= 1'b0;
            srt_q         <= '0;
            irq_q         <= 1'b0;
            for (int i = 0; i < SECTIONS; i++) begin
                sec_q[i] <= '0;
            end
        end else begin
            rtc_rd_pend_q <= rtc_rd_pend_d;
            rtc_em_pend_q <= rtc_em_pend_d;
            srt_rd_pend_q <= srt_rd_pend_d;
            srt_em_pend_q <= srt_em_pend_d;
            sec_q         <= sec_d;
            carry_q       <= carry_d;
            ptr_q         <= ptr_d;
            rtc_dout_q    <= rtc_dout_d;
            div_q         <= div_d;
            rtc_ovf_q     <= rtc_ovf_d;
            srt_q         <= srt_d;
            irq_q         <= irq_d;
        end
    end

    assign rtc_dout     = rtc_dout_q;
    assign rtc_overflow = rtc_ovf_q;
    assign div_clk_out  = div_q;
    assign srt_count    = srt_q;
    assign srt_irq      = irq_q;

    // ---------------- checks ----------------
    logic [3:0] sc_seen_q;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sc_seen_q <= 4'h0;
        end else if (word_tick) begin
            sc_seen_q <= 4'h0;
        end else if (wtc_maj3(tg_shift_q)) begin
            sc_seen_q <= 4'(sc_seen_q + 4'h1);
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_word_after_shifts: assert property (
        word_tick |-> sc_seen_q == 4'(WTC_SHIFT_PULSES))
        else $error("word pulse not after 14 shift pulses");
    a_counters_lockstep: assert property (
        tg_cnt_q[0] == tg_cnt_q[1] && tg_cnt_q[1] == tg_cnt_q[2] && (tg_word_q == 3'h0
        || tg_word_q == 3'h7))
        else $error("timing counters out of step");
    a_count_on_edge: assert property (
        tg_cnt_q[0] != $past(tg_cnt_q[0]) |-> $past(src_edge))
        else $error("timing count moved without source edge");
    a_low_section_step: assert property (
        word_tick |=> sec_q[0] == SEC_W'($past(sec_q[0]) + 1'b1))
        else $error("low section did not step");
    a_carry_gates_next: assert property (
        word_tick && !carry_q[0] |=> sec_q[1] == $past(sec_q[1]))
        else $error("second section stepped without carry");
    a_read_presents: assert property (
        word_tick && rtc_rd && !rtc_em |=> rtc_dout_q == $past(sec_q[ptr_q]))
        else $error("read-in returned wrong section");
    a_emit_restarts: assert property (
        word_tick && rtc_em && !rtc_rd |=> ptr_q == '0)
        else $error("emit did not restart selection");
    a_div_loads_low: assert property (
        word_tick |=> div_q == $past(sec_q[0]))
        else $error("divided-clock buffer not loaded");
    a_wrap_reloads: assert property (
        word_tick && srt_set |=> srt_q == $past(srt_reload) && irq_q)
        else $error("sample counter wrap did not reload and flag");
    a_resync_reloads: assert property (
        word_tick && srt_rd |=> srt_q == $past(srt_reload))
        else $error("read-in did not resync sample counter");
    a_emit_clears_irq: assert property (
        word_tick && srt_em && !srt_set |=> !irq_q)
        else $error("emit did not clear interrupt");
    a_hold_between_words: assert property (
        !word_tick |=> $stable(sec_q[0]) && $stable(srt_q) && $stable(ptr_q))
        else $error("counter state moved off a word boundary");

endmodule

// >>> wtc_lu_model.sv
// processor logic unit model issuing register instructions
module wtc_lu_model
    import wtc_pkg::*;
#(
    parameter int SEC_W = WTC_SEC_W
) (
    input  wire logic        ref_clk,
    output wtc_instr_t       rtc_instr,
    output wtc_instr_t       srt_instr,
    output logic [SEC_W-1:0] srt_reload
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        rtc_instr  = '0;
        srt_instr  = '0;
        srt_reload = '0;
    end
    // one code per call, held a single cycle
    task automatic issue(input logic to_srt, input wtc_ctl_t code);
        @(posedge ref_clk);
        #1;
        if (to_srt) srt_instr = '{sel: 1'b1, code: code};
        else rtc_instr = '{sel: 1'b1, code: code};
        @(posedge ref_clk);
        #1;
        rtc_instr = '0;
        srt_instr = '0;
    endtask
    // holding register written once, then left alone
    task automatic load_reload(input logic [SEC_W-1:0] v);
        @(posedge ref_clk);
        #1;
        srt_reload = v;
    endtask
endmodule

// >>> word_time_counters_bench.sv
// self-checking testbench for the word-time counters
module word_time_counters_bench
    import wtc_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    // narrow sections keep the full rtc wrap near 512 words
    localparam int SW = 3;
    logic          ref_clk, sys_rst, src_clk_a, src_clk_b, src_select;
    logic          srt_step_by_rtc, rtc_overflow, srt_irq;
    wtc_instr_t    rtc_instr, srt_instr;
    wtc_timing_t   timing_out;
    logic [SW-1:0] srt_reload, rtc_dout, div_clk_out, srt_count;
    int            fail_count, n_tests, cycles;

    wtc_counters #(.SEC_W(SW)) wtc_counters_i (.ref_clk, .sys_rst, .src_clk_a,
        .src_clk_b, .src_select, .rtc_instr, .srt_instr, .srt_reload,
        .srt_step_by_rtc, .timing_out, .rtc_dout, .rtc_overflow, .div_clk_out,
        .srt_count, .srt_irq);
    wtc_lu_model #(.SEC_W(SW)) wtc_lu_model_i (.ref_clk, .rtc_instr, .srt_instr,
        .srt_reload);

    initial begin
        ref_clk = 0;
        forever #2 ref_clk = ~ref_clk;
    end
    // sources off the ref_clk grid: 8 and 10 cycles per period
    // scaled stand-in for the word-rate source, 15 pulses a word
    initial begin
        src_clk_a = 0;
        forever #16 src_clk_a = ~src_clk_a;
    end
    initial begin
        src_clk_b = 0;
        forever #20 src_clk_b = ~src_clk_b;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            results();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // returns once the results of a word boundary have landed
    task automatic wait_word;
        int i;
        i = 0;
        do begin
            tick(1);
            i++;
        end while (timing_out.word !== 3'b111 && i < 400);
        if (i >= 400) fail_count++;
        tick(2);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic t_timing(input int span_exp);
        int sh, span;
        wait_word();
        sh = 0;
        span = 0;
        do begin
            tick(1);
            span++;
            if (timing_out.shift === 3'b111) sh++;
            check("vote", 16'(timing_out.shift inside {3'b000, 3'b111}), 1);
        end while (timing_out.word !== 3'b111 && span < 400);
        check("shifts", 16'(sh), 14);
        check("span", 16'(span), 16'(span_exp - 2));
    endtask

    task automatic t_srt;
        wtc_lu_model_i.load_reload(3'h5);
        wait_word();
        wtc_lu_model_i.issue(1'b1, WTC_CTL_EMIT);
        wtc_lu_model_i.issue(1'b1, WTC_CTL_READ);
        wait_word();
        check("resync", srt_count, 3'h5);
        check("irq clr", srt_irq, 0);
        tick(60);
        check("hold", srt_count, 3'h5);
        repeat (2) wait_word();
        check("count", srt_count, 3'h7);
        wait_word();
        check("reload", srt_count, 3'h5);
        check("irq set", srt_irq, 1);
        wtc_lu_model_i.issue(1'b1, WTC_CTL_SHIFT);
        wait_word();
        check("shift", {srt_irq, srt_count}, 4'he);
        wtc_lu_model_i.issue(1'b1, WTC_CTL_EMIT);
        wait_word();
        check("emit", {srt_irq, srt_count}, 4'h7);
        srt_step_by_rtc = 1;
        repeat (2) wait_word();
        check("held", srt_count, 3'h7);
    endtask

    task automatic t_rtc;
        logic [SW-1:0] v, d;
        int i;
        i = 0;
        while (rtc_overflow !== 1'b1 && i < 600) begin
            wait_word();
            i++;
        end
        check("ovf", rtc_overflow, 1);
        wait_word();
        check("ovf one", rtc_overflow, 0);
        check("srt step", {srt_irq, srt_count}, 4'hd);
        wtc_lu_model_i.issue(1'b0, WTC_CTL_READ);
        wait_word();
        wtc_lu_model_i.issue(1'b0, WTC_CTL_EMIT);
        wtc_lu_model_i.issue(1'b0, WTC_CTL_READ);
        wait_word();
        v = rtc_dout;
        d = div_clk_out;
        wtc_lu_model_i.issue(1'b0, WTC_CTL_READ);
        wait_word();
        check("sec1", rtc_dout, 0);
        check("div", div_clk_out, 3'(d + 1));
        wtc_lu_model_i.issue(1'b0, WTC_CTL_READ);
        wait_word();
        check("sec2", rtc_dout, 0);
        wtc_lu_model_i.issue(1'b0, WTC_CTL_READ);
        wait_word();
        check("sec0", rtc_dout, 3'(v + 3));
    endtask

    initial begin
        sys_rst = 1;
        src_select = 0;
        srt_step_by_rtc = 0;
        tick(10);
        sys_rst = 0;
        t_timing(120);
        src_select = 1;
        wait_word();
        t_timing(150);
        src_select = 0;
        wait_word();
        t_srt();
        t_rtc();
        results();
    end
endmodule
